// ===== design/spi_port_pkg.sv
package spi_port_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL3 = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_BAUD = 8'h10;

    // port_status fields
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_BF = 0;
    // port_control_one fields
    localparam int CTRL1_WRITE_COLLISION_FLAG = 7;
    localparam int CTRL1_EN = 5;
    localparam int CTRL1_CKP = 4;
    localparam int CTRL1_MODE_LSB = 0;
    // port_control_three fields
    localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
    localparam int CTRL3_IRQ = 0;

    // Mode field codes
    localparam logic [3:0] MODE_M_DIV4 = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_TMR2 = 4'h3;
    localparam logic [3:0] MODE_S_SEL = 4'h4;
    localparam logic [3:0] MODE_S_NOSEL = 4'h5;
    localparam logic [3:0] MODE_M_BAUD = 4'hA;

    // Reset values
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [7:0] BAUD_RST = 8'h00;

    // Timing: system clock period in ns and serial clock half periods in pclk cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [9:0] HALF_DIV4 = 10'h002;
    localparam logic [9:0] HALF_DIV16 = 10'h008;
    localparam logic [9:0] HALF_DIV64 = 10'h020;
    localparam logic [9:0] HALF_BAUD_ADD = 10'h002;
    localparam logic [4:0] LAST_HALF = 5'h10;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } xfer_state_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } pins_t;

endpackage : spi_port_pkg

// ===== design/sync_serial_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Port idle while enable clear; enabling claims pins; re-enable resets port.
// - Eight-bit shift register moves data most significant bit first.
// - A complete received byte is copied into the receive buffer.
// - Each buffered byte sets buffer-full and the port interrupt flag.
// - Buffer write loads buffer and shift register together.
// - Buffer write during a transfer is dropped and sets write collision.
// - While collision flag is set, buffer writes have no effect.
// - Reading the buffer clears buffer-full.
// - Master transfer starts on buffer write and makes eight clock pulses.
// - Master with output off still receives and flags bytes normally.
// - Master rate: clock over 4, 16, 64, timer tick half, or baud.
// - Baud option: clock over four times reload value plus one.
// - Clock polarity bit sets serial clock idle level.
// - Edge select set: output valid before first clock edge.
// - Control bits live in control-one low six and status top two.
// - Sample phase picks middle or end of output time in master modes; slave ignores it.
// - Master drives serial clock; slave takes it as input.
// - Slave shifts on external clock; flag set when last bit latched.
// - Slave keeps shifting from external clock; byte raises wake flag.
// - Overwrite enable accepts buffer writes while previous byte unread.
// - Status low six bits read-only, upper two bits read-write.
// - Select-controlled slave drives data out only while select low.
// - Select high or port disable forces bit counter to zero.
// - Data shifts out on one clock edge, latched on the other except in master with sample phase set.
module sync_serial_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    input wire logic sdi,
    input wire logic ss_n,
    input wire logic timer2_tick,
    output spi_port_pkg::pins_t pins,
    output logic irq_flag
);

    // Half period of the master serial clock in pclk cycles
    function automatic logic [9:0] half_len(input logic [3:0] m, input logic [7:0] b);
        case (m)
            spi_port_pkg::MODE_M_DIV16: half_len = spi_port_pkg::HALF_DIV16;
            spi_port_pkg::MODE_M_DIV64: half_len = spi_port_pkg::HALF_DIV64;
            spi_port_pkg::MODE_M_BAUD: half_len = {1'b0, b, 1'b0} + spi_port_pkg::HALF_BAUD_ADD;
            default: half_len = spi_port_pkg::HALF_DIV4;
        endcase
    endfunction : half_len

    function automatic logic is_master(input logic [3:0] m);
        is_master = (m == spi_port_pkg::MODE_M_DIV4) || (m == spi_port_pkg::MODE_M_DIV16)
            || (m == spi_port_pkg::MODE_M_DIV64) || (m == spi_port_pkg::MODE_M_TMR2)
            || (m == spi_port_pkg::MODE_M_BAUD);
    endfunction : is_master

    // Odd halves are leading edges. With late sampling the capture moves one half
    // later; the eighth capture then lands on the final return to idle.
    function automatic logic sample_half(input logic [4:0] h, input logic e, input logic s);
        if (!s)
            sample_half = e ? h[0] : !h[0];
        else if (e)
            sample_half = !h[0];
        else
            sample_half = (h[0] && h != 5'h01) || (h == spi_port_pkg::LAST_HALF);
    endfunction : sample_half

    logic [3:0] mode_reg;
    logic en_reg;
    logic ckp_reg;
    logic write_collision_flag_reg;
    logic smp_reg;
    logic cke_reg;
    logic bf_reg;
    logic buffer_overwrite_enable_reg;
    logic irq_reg;
    logic [7:0] baud_reg;
    logic [7:0] data_buf_reg;
    logic [7:0] shift_reg;
    logic sdo_reg;
    logic [2:0] bit_cnt_reg;
    logic sck_prev_reg;
    spi_port_pkg::xfer_state_t state_reg;
    logic [9:0] div_cnt_reg;
    logic [4:0] half_cnt_reg;
    logic sck_lvl_reg;

    logic acc_first;
    logic acc_done;
    logic wr;
    logic rd_data;
    logic wr_data;
    logic master;
    logic slave_sel;
    logic slave_on;
    logic sel_reset;
    logic in_progress;
    logic load_ok;
    logic m_tick;
    logic [4:0] h_new;
    logic lead;
    logic trail;
    logic do_sample;
    logic do_output;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [9:0] half_m1;

    assign acc_first = psel && penable && !pready;
    assign acc_done = psel && penable && pready;
    assign wr = acc_done && pwrite;
    assign rd_data = acc_done && !pwrite && (paddr == spi_port_pkg::OFF_DATA);
    assign wr_data = wr && (paddr == spi_port_pkg::OFF_DATA);

    assign master = is_master(mode_reg);
    assign slave_sel = (mode_reg == spi_port_pkg::MODE_S_NOSEL)
        || ((mode_reg == spi_port_pkg::MODE_S_SEL) && !ss_n);
    assign slave_on = en_reg && slave_sel;
    assign sel_reset = (mode_reg == spi_port_pkg::MODE_S_SEL) && ss_n;
    assign in_progress = master ? (state_reg != spi_port_pkg::ST_IDLE) : (bit_cnt_reg != 3'h0);

    assign load_ok = wr_data && en_reg && !write_collision_flag_reg && !in_progress && (buffer_overwrite_enable_reg || !bf_reg);

    assign half_m1 = half_len(mode_reg, baud_reg) - 10'h001;
    assign m_tick = (state_reg == spi_port_pkg::ST_SHIFT)
        && ((mode_reg == spi_port_pkg::MODE_M_TMR2) ? timer2_tick : (div_cnt_reg == half_m1));
    assign h_new = half_cnt_reg + 5'h01;

    // Slave edges; clock taken as synchronous, so one sample of history suffices
    assign lead = (sck_in ^ ckp_reg) && !(sck_prev_reg ^ ckp_reg);
    assign trail = !(sck_in ^ ckp_reg) && (sck_prev_reg ^ ckp_reg);

    always_comb
    begin
        if (master)
        begin
            do_sample = m_tick && sample_half(h_new, cke_reg, smp_reg);
            do_output = m_tick && (cke_reg ? !h_new[0] : h_new[0])
                && (h_new != spi_port_pkg::LAST_HALF);
        end
        else
        begin
            do_sample = slave_on && (cke_reg ? lead : trail);
            do_output = slave_on && (cke_reg ? trail : lead);
        end
    end

    assign rx_byte = {shift_reg[6:0], sdi};
    assign byte_done = do_sample && (bit_cnt_reg == spi_port_pkg::LAST_BIT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sck_prev_reg <= 1'b0;
        else
            sck_prev_reg <= sck_in;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= spi_port_pkg::ST_IDLE;
            div_cnt_reg <= 10'h000;
            half_cnt_reg <= 5'h00;
            sck_lvl_reg <= 1'b0;
        end
        else if (!en_reg || !master)
        begin
            state_reg <= spi_port_pkg::ST_IDLE;
            div_cnt_reg <= 10'h000;
            half_cnt_reg <= 5'h00;
            sck_lvl_reg <= ckp_reg;
        end
        else
        begin
            case (state_reg)
                spi_port_pkg::ST_IDLE:
                begin
                    sck_lvl_reg <= ckp_reg;
                    div_cnt_reg <= 10'h000;
                    half_cnt_reg <= 5'h00;
                    if (load_ok)
                        state_reg <= spi_port_pkg::ST_SHIFT;
                end
                spi_port_pkg::ST_SHIFT:
                begin
                    if (m_tick)
                    begin
                        div_cnt_reg <= 10'h000;
                        sck_lvl_reg <= !sck_lvl_reg;
                        half_cnt_reg <= h_new;
                        if (h_new == spi_port_pkg::LAST_HALF)
                            state_reg <= spi_port_pkg::ST_IDLE;
                    end
                    else
                        div_cnt_reg <= div_cnt_reg + 10'h001;
                end
                default: state_reg <= spi_port_pkg::ST_IDLE;
            endcase
        end
    end

    // shift path, shared by master and slave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_reg <= 8'h00;
            sdo_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
        end
        else if (!en_reg)
            bit_cnt_reg <= 3'h0;
        // A deselected slave must still take its next reply byte
        else if (load_ok)
        begin
            // first bit ready before any edge
            shift_reg <= pwdata[7:0];
            sdo_reg <= pwdata[7];
            bit_cnt_reg <= 3'h0;
        end
        else if (sel_reset)
            bit_cnt_reg <= 3'h0;
        else
        begin
            // receive continues regardless of output enable
            if (do_sample)
            begin
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (do_output)
                sdo_reg <= do_sample ? rx_byte[7] : shift_reg[7];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= spi_port_pkg::MODE_RST;
            en_reg <= 1'b0;
            ckp_reg <= 1'b0;
            smp_reg <= 1'b0;
            cke_reg <= 1'b0;
            buffer_overwrite_enable_reg <= 1'b0;
            baud_reg <= spi_port_pkg::BAUD_RST;
        end
        else if (wr)
        begin
            case (paddr)
                spi_port_pkg::OFF_CTRL1:
                begin
                    mode_reg <= pwdata[spi_port_pkg::CTRL1_MODE_LSB +: 4];
                    en_reg <= pwdata[spi_port_pkg::CTRL1_EN];
                    ckp_reg <= pwdata[spi_port_pkg::CTRL1_CKP];
                end
                spi_port_pkg::OFF_STATUS:
                begin
                    smp_reg <= pwdata[spi_port_pkg::STAT_SMP];
                    cke_reg <= pwdata[spi_port_pkg::STAT_CKE];
                end
                spi_port_pkg::OFF_CTRL3: buffer_overwrite_enable_reg <= pwdata[spi_port_pkg::CTRL3_BUFFER_OVERWRITE_ENABLE];
                spi_port_pkg::OFF_BAUD: baud_reg <= pwdata[7:0];
                default: baud_reg <= baud_reg;
            endcase
        end
    end

    // Flags: a hardware set in the same cycle as a software clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bf_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (byte_done)
                bf_reg <= 1'b1;
            else if (rd_data)
                bf_reg <= 1'b0;
            if (wr_data && en_reg && in_progress)
                write_collision_flag_reg <= 1'b1;
            else if (wr && (paddr == spi_port_pkg::OFF_CTRL1))
                write_collision_flag_reg <= pwdata[spi_port_pkg::CTRL1_WRITE_COLLISION_FLAG];
            if (byte_done)
                irq_reg <= 1'b1;
            else if (wr && (paddr == spi_port_pkg::OFF_CTRL3))
                irq_reg <= pwdata[spi_port_pkg::CTRL3_IRQ];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_buf_reg <= 8'h00;
        else if (byte_done)
            data_buf_reg <= rx_byte;
        else if (load_ok)
            data_buf_reg <= pwdata[7:0];
    end

    // APB: one wait state so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc_first;
            pslverr <= 1'b0;
            if (acc_first)
            begin
                case (paddr)
                    spi_port_pkg::OFF_STATUS:
                        prdata <= {24'h000000, smp_reg, cke_reg, 5'h00, bf_reg};
                    spi_port_pkg::OFF_CTRL1:
                        prdata <= {24'h000000, write_collision_flag_reg, 1'b0, en_reg, ckp_reg, mode_reg};
                    spi_port_pkg::OFF_CTRL3:
                        prdata <= {24'h000000, 3'h0, buffer_overwrite_enable_reg, 3'h0, irq_reg};
                    spi_port_pkg::OFF_DATA: prdata <= {24'h000000, data_buf_reg};
                    spi_port_pkg::OFF_BAUD: prdata <= {24'h000000, baud_reg};
                    default:
                    begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins <= '0;
            irq_flag <= 1'b0;
        end
        else
        begin
            pins.sck_o <= (state_reg == spi_port_pkg::ST_IDLE) ? ckp_reg : sck_lvl_reg;
            pins.sck_oe <= en_reg && master;
            pins.sdo_o <= sdo_reg;
            pins.sdo_oe <= en_reg && (master || slave_sel);
            irq_flag <= irq_reg;
        end
    end

    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_byte_in;
        byte_done;
    endsequence

    sequence s_master_load;
        load_ok && master;
    endsequence

    a_msb_first_byte: assert property (s_byte_in |=> data_buf_reg == $past(rx_byte))
        else $error("received byte not buffered in shift order");
    a_full_and_flag: assert property (s_byte_in |=> bf_reg && irq_reg)
        else $error("byte buffered without full and interrupt flags");
    a_write_loads_both: assert property (load_ok |=>
        shift_reg == $past(pwdata[7:0]) && data_buf_reg == $past(pwdata[7:0]))
        else $error("buffer write did not load both registers");
    a_collision_sets: assert property (wr_data && en_reg && in_progress |=>
        write_collision_flag_reg && (shift_reg == ($past(do_sample) ? $past(rx_byte) : $past(shift_reg))))
        else $error("write during transfer not flagged or not dropped");
    a_write_collision_flag_blocks: assert property (write_collision_flag_reg |-> !load_ok)
        else $error("write accepted while collision flag set");
    a_read_clears_full: assert property (rd_data && !byte_done |=> !bf_reg)
        else $error("buffer read left full flag set");
    a_master_starts: assert property (s_master_load |=>
        state_reg == spi_port_pkg::ST_SHIFT ##1 pins.sck_oe)
        else $error("master write did not start a transfer");
    a_idle_polarity: assert property (state_reg == spi_port_pkg::ST_IDLE |=>
        pins.sck_o == $past(ckp_reg))
        else $error("idle serial clock not at polarity level");
    a_select_float: assert property (sel_reset |=> !pins.sdo_oe)
        else $error("data out driven while select high");
    a_counter_reset: assert property (!en_reg || sel_reset |=> bit_cnt_reg == 3'h0)
        else $error("bit counter not cleared on port reset");
    a_disabled_quiet: assert property (!en_reg |=> !pins.sck_oe && !pins.sdo_oe)
        else $error("pins driven while port disabled");

endmodule : sync_serial_port

// ===== testbench/spi_far_end.sv
`timescale 1ns/10ps
module spi_far_end (
    input wire logic pclk,
    input wire spi_port_pkg::pins_t pins,
    output logic sck_in,
    output logic sdi,
    output logic ss_n
);
    logic [7:0] reply;
    logic [7:0] heard;
    logic busy;
    int idx;

    initial
    begin
        sck_in = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
        busy = 1'b0;
        idx = 8;
        reply = 8'h00;
        heard = 8'h00;
    end

    // Outside a frame the line keeps moving so a stale bit is never taken as data
    always @(posedge pclk)
    begin
        if (!busy && idx == 8)
            sdi <= ~sdi;
    end

    always @(posedge pins.sck_o)
    begin
        if (pins.sck_oe === 1'b1)
        begin
            if (idx == 8)
                idx = 0;
            sdi <= reply[7 - idx];
        end
    end

    always @(negedge pins.sck_o)
    begin
        if (pins.sck_oe === 1'b1 && idx < 8)
        begin
            heard <= {heard[6:0], pins.sdo_o};
            idx = idx + 1;
        end
    end

    task automatic send(input logic [7:0] b, input int nbits);
        busy = 1'b1;
        @(posedge pclk);
        ss_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int i = 7; i > 7 - nbits; i--)
        begin
            sck_in <= 1'b1;
            sdi <= b[i];
            repeat (4) @(posedge pclk);
            heard <= {heard[6:0], pins.sdo_o};
            sck_in <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        ss_n <= 1'b1;
        busy = 1'b0;
    endtask : send
endmodule : spi_far_end

// ===== testbench/sync_serial_port_spi_mode_tb_top.sv
`timescale 1ns/10ps
module sync_serial_port_spi_mode_tb_top;
    localparam logic [7:0] ST = spi_port_pkg::OFF_STATUS;
    localparam logic [7:0] C1 = spi_port_pkg::OFF_CTRL1;
    localparam logic [7:0] C3 = spi_port_pkg::OFF_CTRL3;
    localparam logic [7:0] DT = spi_port_pkg::OFF_DATA;
    localparam logic [7:0] BD = spi_port_pkg::OFF_BAUD;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sck_in, sdi, ss_n, timer2_tick, irq_flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    spi_port_pkg::pins_t pins;
    logic last_sck = 1'b0;
    logic [32:0] expect_q[$];
    logic [7:0] tx, b;
    int failures = 0;
    int checks_done = 0;
    int seed = 42999;
    int cycles = 0;
    int since = 0;
    int half_seen = 0;
    int tick_gap = 3;

    sync_serial_port dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_in), .sdi(sdi), .ss_n(ss_n),
        .timer2_tick(timer2_tick), .pins(pins), .irq_flag(irq_flag)
    );

    spi_far_end far (.pclk(pclk), .pins(pins), .sck_in(sck_in), .sdi(sdi), .ss_n(ss_n));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checks_done++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Idle cycle first so psel is never dropped and raised in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($random(seed)), d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] want);
        expect_q.push_back(want);
        apb(1'b0, a, 8'h00);
    endtask : rd

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq_flag !== 1'b1 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        check({32'h0, irq_flag}, 33'h1);
    endtask : wait_irq

    task automatic master_byte(input logic [3:0] mode, input int half, input logic collide);
        tx = 8'($random(seed));
        far.reply = 8'($random(seed));
        apb(1'b1, C1, {4'h2, mode});
        apb(1'b1, DT, tx);
        if (collide)
        begin
            repeat (40) @(posedge pclk);
            apb(1'b1, DT, ~tx);
        end
        wait_irq(20 * half + 50);
        repeat (2) @(posedge pclk);
        check(33'(half_seen), 33'(half));
        check({25'h0, far.heard}, {25'h0, tx});
        rd(ST, 33'h001);
        rd(C3, 33'h001);
        rd(DT, {25'h0, far.reply});
        rd(ST, 33'h000);
        apb(1'b1, C3, 8'h00);
    endtask : master_byte

    // Read results are paired with the oldest note in arrival order
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            if (expect_q.size() == 0)
                check({pslverr, prdata}, 'x);
            else
                check({pslverr, prdata}, expect_q.pop_front());
        end
    end

    // Half-period meter on the clock pin, timer pulses and the run limit
    always @(posedge pclk)
    begin
        cycles++;
        timer2_tick <= (cycles % tick_gap == 0);
        if (pins.sck_o !== last_sck)
        begin
            half_seen = since;
            since = 1;
            last_sck = pins.sck_o;
        end
        else
            since++;
        if (cycles > 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer2_tick = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ST, 33'h0);
        rd(C1, 33'h0);
        rd(C3, 33'h0);
        rd(BD, 33'h0);
        rd(8'h14, 33'h100000000);
        apb(1'b1, ST, 8'hFF);
        rd(ST, 33'h0C0);
        apb(1'b1, ST, 8'h00);
        apb(1'b1, DT, 8'h5A);
        repeat (50) @(posedge pclk);
        check({32'h0, pins.sck_oe | irq_flag}, 33'h0);
        apb(1'b1, C1, 8'h10);
        repeat (3) @(posedge pclk);
        check({32'h0, pins.sck_o}, 33'h1);
        tick_gap = 3 + ($random(seed) & 3);
        b = 8'($random(seed) & 3);
        apb(1'b1, BD, b);
        master_byte(4'h0, 2, 1'b0);
        master_byte(4'h1, 8, 1'b0);
        master_byte(4'h2, 32, 1'b1);
        rd(C1, 33'h0A2);
        apb(1'b1, DT, 8'h77);
        repeat (150) @(posedge pclk);
        check(33'(since >= 150), 33'h1);
        master_byte(4'h3, tick_gap, 1'b0);
        master_byte(4'hA, 2 * (b + 1), 1'b0);
        apb(1'b1, DT, 8'hC3);
        wait_irq(200);
        apb(1'b1, C3, 8'h00);
        apb(1'b1, DT, 8'h3C);
        repeat (150) @(posedge pclk);
        check(33'(since >= 150), 33'h1);
        far.reply = 8'h96;
        apb(1'b1, C3, 8'h10);
        apb(1'b1, DT, 8'h3C);
        wait_irq(200);
        rd(DT, 33'h096);
        apb(1'b1, C1, 8'h00);
        apb(1'b1, C3, 8'h00);
        apb(1'b1, C1, 8'h24);
        tx = 8'($random(seed));
        apb(1'b1, DT, tx);
        far.send(8'hB4, 8);
        wait_irq(40);
        check({25'h0, far.heard}, {25'h0, tx});
        rd(DT, 33'h0B4);
        apb(1'b1, C3, 8'h00);
        far.send(8'hFF, 4);
        repeat (3) @(posedge pclk);
        check({32'h0, pins.sdo_oe | pins.sck_oe | irq_flag}, 33'h0);
        far.send(8'h5D, 8);
        wait_irq(40);
        rd(DT, 33'h05D);
        repeat (5) @(posedge pclk);
        check(33'(expect_q.size()), 33'h0);
        tally_and_finish();
    end
endmodule : sync_serial_port_spi_mode_tb_top
